// file: msl_sync_ctrl.sv
// Overview of operation
// - two lamps show no link, aligned, data
// - point to point uses extended sync automatically
// - master fans out to followers, star only
// - software selects master, follower or stand-alone
// - stand-alone ignores the link completely
// - master and stand-alone record time information; a follower does not
// - follower disables time source, follows master
// - master time from RTC, PTP, IRIG or GPS
// - align first sample, share ticks, triggers, delay
// - start, pause, trigger synchronous; stop is not
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module msl_sync_ctrl
  import msl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_sig_det,
  input wire logic rx_align_det,
  input wire logic rx_valid_det,
  input wire logic rx_trig,
  input wire logic rx_start,
  input wire logic rx_pause,
  input wire logic rx_stop,
  input wire logic rx_tick,
  input wire logic chan_trig_in,
  output logic led_sig_detect,
  output logic led_data,
  output logic tx_trig,
  output logic tx_start,
  output logic tx_pause,
  output logic tx_stop,
  output logic tx_tick,
  output logic sample_tick,
  output logic first_sample,
  output logic rec_active,
  output logic rec_paused,
  output logic trig_out,
  output logic [1:0] time_src_sel,
  output logic time_src_en,
  output logic time_rec_en,
  output logic irq
);
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] src;
    logic [7:0] dly;
    logic [15:0] div;
    logic [MSL_IRQ_W-1:0] int_stat;
    logic [MSL_IRQ_W-1:0] int_mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] div_cnt;
    logic [7:0] dly_cnt;
    logic [2:0] pend;
    logic rec;
    logic paused;
    logic arm_first;
    logic first;
    logic tick;
    logic trig;
    logic tx_trig;
    logic tx_start;
    logic tx_pause;
    logic tx_stop;
    logic tx_tick;
    logic [1:0] tsel;
    logic tsen;
    logic trec;
    logic irq;
  } msl_ctrl_t;

  msl_ctrl_t r_reg;
  msl_ctrl_t r_next;
  msl_link_if lnk();

  logic is_m;
  logic is_f;
  assign is_m = (r_reg.mode == MSL_MODE_MASTER);
  assign is_f = (r_reg.mode == MSL_MODE_FOLLOW);
  // mode code 3 decodes as stand-alone, so a stray code keeps the link off
  assign lnk.enable = is_m | is_f;

  msl_link_mon u_mon (
    .pclk(pclk),
    .presetn(presetn),
    .rx_sig_det(rx_sig_det),
    .rx_align_det(rx_align_det),
    .rx_valid_det(rx_valid_det),
    .rx_trig(rx_trig),
    .rx_start(rx_start),
    .rx_pause(rx_pause),
    .rx_stop(rx_stop),
    .rx_tick(rx_tick),
    .lnk(lnk)
  );

  always_comb begin
    logic acc;
    logic wr;
    logic hit;
    logic linked;
    logic loc_tick;
    logic [3:0] cmd;
    logic [2:0] req;
    logic [2:0] act;
    logic stop_now;
    logic [31:0] rd;
    logic [MSL_IRQ_W-1:0] ev;
    logic [MSL_IRQ_W-1:0] w1c;
    acc = psel & penable;
    wr = acc & r_reg.pready & pwrite;
    hit = 1'b1;
    linked = (lnk.state == MSL_DATA);
    loc_tick = 1'b0;
    cmd = 4'h0;
    req = 3'h0;
    act = 3'h0;
    stop_now = 1'b0;
    rd = 32'h0000_0000;
    ev = '0;
    w1c = '0;
    r_next = r_reg;

    // bus: one wait state, then pready from a flop
    r_next.pready = acc & ~r_reg.pready;
    // unmapped offsets read as zero and answer with pslverr
    unique case (paddr)
      MSL_OFF_CTRL: rd[3:0] = {r_reg.src, r_reg.mode};
      MSL_OFF_STATUS: begin
        rd[MSL_ST_LINK_LSB +: 3] = lnk.state;
        rd[MSL_ST_REC] = r_reg.rec;
        rd[MSL_ST_PAUSED] = r_reg.paused;
        rd[MSL_ST_MODE_LSB +: 2] = r_reg.mode;
      end
      MSL_OFF_INT_STAT: rd[MSL_IRQ_W-1:0] = r_reg.int_stat;
      MSL_OFF_INT_MASK: rd[MSL_IRQ_W-1:0] = r_reg.int_mask;
      MSL_OFF_CMD: rd = 32'h0000_0000;
      MSL_OFF_CABLE_DLY: rd[7:0] = r_reg.dly;
      MSL_OFF_SAMPLE_DIV: rd[15:0] = r_reg.div;
      default: hit = 1'b0;
    endcase
    if (acc && !r_reg.pready) begin
      r_next.prdata = pwrite ? 32'h0000_0000 : rd;
      r_next.pslverr = ~hit;
    end else begin
      r_next.pslverr = 1'b0;
    end
    if (wr) begin
      unique case (paddr)
        MSL_OFF_CTRL: begin
          r_next.mode = pwdata[MSL_CTRL_MODE_LSB +: 2];
          r_next.src = pwdata[MSL_CTRL_SRC_LSB +: 2];
        end
        MSL_OFF_INT_STAT: w1c = pwdata[MSL_IRQ_W-1:0];
        MSL_OFF_INT_MASK: r_next.int_mask = pwdata[MSL_IRQ_W-1:0];
        MSL_OFF_CMD: cmd = pwdata[3:0];
        MSL_OFF_CABLE_DLY: r_next.dly = pwdata[7:0];
        MSL_OFF_SAMPLE_DIV: r_next.div = pwdata[15:0];
        default: ;
      endcase
    end

    // sample clock: a follower never runs its own divider, so no drift
    if (is_f) begin
      loc_tick = lnk.rx_tick_p;
      r_next.div_cnt = 16'h0000;
    end else if (r_reg.div_cnt >= r_reg.div) begin
      loc_tick = 1'b1;
      r_next.div_cnt = 16'h0000;
    end else begin
      r_next.div_cnt = r_reg.div_cnt + 16'h0001;
    end
    r_next.tick = loc_tick;
    r_next.tx_tick = is_m & loc_tick;

    // start, pause and trigger requests {trig, pause, start}
    req = {cmd[MSL_CMD_TRIG] | chan_trig_in,
           cmd[MSL_CMD_PAUSE], cmd[MSL_CMD_START]};
    stop_now = cmd[MSL_CMD_STOP];
    r_next.tx_trig = 1'b0;
    r_next.tx_start = 1'b0;
    r_next.tx_pause = 1'b0;
    r_next.tx_stop = 1'b0;
    if (is_f) begin
      // a follower asks upstream and acts on the master's echo
      r_next.tx_start = linked & req[0];
      r_next.tx_pause = linked & req[1];
      r_next.tx_trig = linked & req[2];
      r_next.tx_stop = linked & stop_now;
      act = {lnk.rx_trig_p, lnk.rx_pause_p, lnk.rx_start_p};
      stop_now = stop_now | lnk.rx_stop_p;
    end else begin
      if (is_m) begin
        // follower requests are re-sent to every follower port
        req = req | {lnk.rx_trig_p, lnk.rx_pause_p, lnk.rx_start_p};
        stop_now = stop_now | lnk.rx_stop_p;
        // extended set always on when a partner is linked
        r_next.tx_start = linked & req[0];
        r_next.tx_pause = linked & req[1];
        r_next.tx_trig = linked & req[2];
        r_next.tx_stop = linked & stop_now;
      end
      // master waits one cable delay so both ends act together;
      // requests during a wait join the pending group
      // limitation: a stop does not flush a start still held in the group
      if (!is_m || r_reg.dly == 8'h00) begin
        act = req | r_reg.pend;
        r_next.pend = 3'h0;
        r_next.dly_cnt = 8'h00;
      end else if (r_reg.pend == 3'h0) begin
        r_next.pend = req;
        r_next.dly_cnt = r_reg.dly;
      end else if (r_reg.dly_cnt <= 8'h01) begin
        act = r_reg.pend | req;
        r_next.pend = 3'h0;
        r_next.dly_cnt = 8'h00;
      end else begin
        r_next.pend = r_reg.pend | req;
        r_next.dly_cnt = r_reg.dly_cnt - 8'h01;
      end
    end

    // recording state; stop is applied at once, unsynchronised
    if (stop_now) begin
      r_next.rec = 1'b0;
      r_next.paused = 1'b0;
      r_next.arm_first = 1'b0;
    end else if (act[0]) begin
      if (!r_reg.rec) begin
        r_next.arm_first = 1'b1;
      end
      r_next.rec = 1'b1;
      r_next.paused = 1'b0;
    end else if (act[1] && r_reg.rec) begin
      r_next.paused = 1'b1;
    end
    // first_sample marks the tick that lines up all units after a start
    r_next.first = 1'b0;
    if (r_next.arm_first && loc_tick) begin
      r_next.first = 1'b1;
      r_next.arm_first = 1'b0;
    end
    r_next.trig = act[2];

    // time base: follower has no source and records no time
    // a follower must not stamp time of its own; the master owns it
    r_next.tsen = ~is_f;
    r_next.tsel = is_f ? MSL_SRC_RTC : r_reg.src;
    r_next.trec = ~is_f & r_next.rec;

    // a stop in the same cycle as a start wins, so no start is flagged
    ev[MSL_IRQ_UP] = lnk.up_p;
    ev[MSL_IRQ_LOST] = lnk.lost_p;
    ev[MSL_IRQ_START] = act[0] & ~stop_now;
    ev[MSL_IRQ_STOP] = stop_now;
    ev[MSL_IRQ_TRIG] = act[2];
    // a new event beats a clear in the same cycle
    r_next.int_stat = (r_reg.int_stat & ~w1c) | ev;
    r_next.irq = |(r_next.int_stat & r_next.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{mode: MSL_MODE_RST, src: MSL_SRC_RST, dly: MSL_DLY_RST,
                 div: MSL_DIV_RST, prdata: 32'h0000_0000,
                 div_cnt: 16'h0000, dly_cnt: 8'h00, tsen: 1'b1,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign led_sig_detect = lnk.led_sig;
  assign led_data = lnk.led_data;
  assign tx_trig = r_reg.tx_trig;
  assign tx_start = r_reg.tx_start;
  assign tx_pause = r_reg.tx_pause;
  assign tx_stop = r_reg.tx_stop;
  assign tx_tick = r_reg.tx_tick;
  assign sample_tick = r_reg.tick;
  assign first_sample = r_reg.first;
  assign rec_active = r_reg.rec;
  assign rec_paused = r_reg.paused;
  assign trig_out = r_reg.trig;
  assign time_src_sel = r_reg.tsel;
  assign time_src_en = r_reg.tsen;
  assign time_rec_en = r_reg.trec;
  assign irq = r_reg.irq;
endmodule : msl_sync_ctrl
`default_nettype wire

// file: msl_pkg.sv
package msl_pkg;
  // register byte offsets
  localparam logic [7:0] MSL_OFF_CTRL = 8'h00;
  localparam logic [7:0] MSL_OFF_STATUS = 8'h04;
  localparam logic [7:0] MSL_OFF_INT_STAT = 8'h08;
  localparam logic [7:0] MSL_OFF_INT_MASK = 8'h0C;
  localparam logic [7:0] MSL_OFF_CMD = 8'h10;
  localparam logic [7:0] MSL_OFF_CABLE_DLY = 8'h14;
  localparam logic [7:0] MSL_OFF_SAMPLE_DIV = 8'h18;

  // control field positions and codes
  localparam int MSL_CTRL_MODE_LSB = 0;
  localparam int MSL_CTRL_SRC_LSB = 2;
  localparam logic [1:0] MSL_MODE_ALONE = 2'h0;
  localparam logic [1:0] MSL_MODE_MASTER = 2'h1;
  localparam logic [1:0] MSL_MODE_FOLLOW = 2'h2;
  localparam logic [1:0] MSL_SRC_RTC = 2'h0;
  localparam logic [1:0] MSL_SRC_PTP = 2'h1;
  localparam logic [1:0] MSL_SRC_IRIG = 2'h2;
  localparam logic [1:0] MSL_SRC_GPS = 2'h3;

  // command bits, self clearing
  localparam int MSL_CMD_START = 0;
  localparam int MSL_CMD_STOP = 1;
  localparam int MSL_CMD_PAUSE = 2;
  localparam int MSL_CMD_TRIG = 3;

  // interrupt status / mask bits
  localparam int MSL_IRQ_W = 5;
  localparam int MSL_IRQ_UP = 0;
  localparam int MSL_IRQ_LOST = 1;
  localparam int MSL_IRQ_START = 2;
  localparam int MSL_IRQ_STOP = 3;
  localparam int MSL_IRQ_TRIG = 4;

  // status field positions
  localparam int MSL_ST_LINK_LSB = 0;
  localparam int MSL_ST_REC = 3;
  localparam int MSL_ST_PAUSED = 4;
  localparam int MSL_ST_MODE_LSB = 5;

  // reset values
  localparam logic [1:0] MSL_MODE_RST = 2'h0;
  localparam logic [1:0] MSL_SRC_RST = 2'h0;
  localparam logic [7:0] MSL_DLY_RST = 8'h00;
  localparam logic [15:0] MSL_DIV_RST = 16'h0009;

  // receiver inputs handled by the link monitor
  localparam int MSL_RX_W = 8;
  localparam int MSL_EV_W = 5;

  typedef enum logic [2:0] {
    MSL_NO_LINK = 3'b001,
    MSL_ALIGNED = 3'b010,
    MSL_DATA = 3'b100
  } msl_link_t;
endpackage : msl_pkg

// file: msl_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface msl_link_if;
  import msl_pkg::*;
  logic enable;
  msl_link_t state;
  logic led_sig;
  logic led_data;
  logic up_p;
  logic lost_p;
  logic rx_trig_p;
  logic rx_start_p;
  logic rx_pause_p;
  logic rx_stop_p;
  logic rx_tick_p;
  modport mon (
    input enable,
    output state, led_sig, led_data, up_p, lost_p,
    output rx_trig_p, rx_start_p, rx_pause_p, rx_stop_p, rx_tick_p
  );
  modport ctl (
    output enable,
    input state, led_sig, led_data, up_p, lost_p,
    input rx_trig_p, rx_start_p, rx_pause_p, rx_stop_p, rx_tick_p
  );
endinterface : msl_link_if
`default_nettype wire

// file: msl_link_mon.sv
`timescale 1ns/10ps
`default_nettype none
module msl_link_mon
  import msl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_sig_det,
  input wire logic rx_align_det,
  input wire logic rx_valid_det,
  input wire logic rx_trig,
  input wire logic rx_start,
  input wire logic rx_pause,
  input wire logic rx_stop,
  input wire logic rx_tick,
  msl_link_if.mon lnk
);
  typedef struct packed {
    logic [MSL_RX_W-1:0] s1;
    logic [MSL_RX_W-1:0] s2;
    logic [MSL_EV_W-1:0] prev;
    msl_link_t state;
    logic led_sig;
    logic led_data;
    logic up;
    logic lost;
    logic [MSL_EV_W-1:0] ev;
  } msl_mon_t;

  msl_mon_t r_reg;
  msl_mon_t r_next;
  logic sig;
  logic align;
  logic valid;
  logic [MSL_EV_W-1:0] lvl;

  assign sig = r_reg.s2[0];
  assign align = r_reg.s2[1];
  assign valid = r_reg.s2[2];
  assign lvl = r_reg.s2[7:3];

  always_comb begin
    r_next = r_reg;
    r_next.s1 = {rx_tick, rx_stop, rx_pause, rx_start, rx_trig,
                 rx_valid_det, rx_align_det, rx_sig_det};
    r_next.s2 = r_reg.s1;
    r_next.prev = lvl;
    r_next.up = 1'b0;
    r_next.lost = 1'b0;
    if (!lnk.enable) begin
      r_next.state = MSL_NO_LINK;
    end else begin
      unique case (r_reg.state)
        MSL_NO_LINK: begin
          if (sig && align) begin
            r_next.state = MSL_ALIGNED;
          end
        end
        MSL_ALIGNED: begin
          if (!sig || !align) begin
            r_next.state = MSL_NO_LINK;
          end else if (valid) begin
            r_next.state = MSL_DATA;
            r_next.up = 1'b1;
          end
        end
        MSL_DATA: begin
          if (!sig || !align) begin
            r_next.state = MSL_NO_LINK;
            r_next.lost = 1'b1;
          end else if (!valid) begin
            r_next.state = MSL_ALIGNED;
            r_next.lost = 1'b1;
          end
        end
        default: r_next.state = MSL_NO_LINK;
      endcase
    end
    // two lamps: off/off, on/off, on/on
    r_next.led_sig = (r_next.state != MSL_NO_LINK);
    r_next.led_data = (r_next.state == MSL_DATA);
    // remote commands count only while valid data flows
    r_next.ev = (r_reg.state == MSL_DATA) ? (lvl & ~r_reg.prev) : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{s1: '0, s2: '0, prev: '0, state: MSL_NO_LINK,
                 led_sig: 1'b0, led_data: 1'b0, up: 1'b0, lost: 1'b0,
                 ev: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign lnk.state = r_reg.state;
  assign lnk.led_sig = r_reg.led_sig;
  assign lnk.led_data = r_reg.led_data;
  assign lnk.up_p = r_reg.up;
  assign lnk.lost_p = r_reg.lost;
  assign lnk.rx_trig_p = r_reg.ev[0];
  assign lnk.rx_start_p = r_reg.ev[1];
  assign lnk.rx_pause_p = r_reg.ev[2];
  assign lnk.rx_stop_p = r_reg.ev[3];
  assign lnk.rx_tick_p = r_reg.ev[4];
endmodule : msl_link_mon
`default_nettype wire

// file: msl_sync_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module msl_sync_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_sig_det,
  input wire logic rx_valid_det,
  input wire logic led_sig_detect,
  input wire logic led_data,
  input wire logic tx_start,
  input wire logic tx_stop,
  input wire logic rec_active,
  input wire logic sample_tick,
  input wire logic first_sample,
  input wire logic [1:0] time_src_sel,
  input wire logic time_src_en,
  input wire logic time_rec_en
);
  default clocking mcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_LAMP_ORDER: assert property (led_data |-> led_sig_detect)
    else $error("data lamp on without signal lamp");
  // five idle samples cover the two synchroniser flops and the state flop
  AST_SIG_LOSS: assert property (!rx_sig_det [*5] |-> !led_sig_detect)
    else $error("signal lamp stays on without light");
  AST_DATA_LOSS: assert property (!rx_valid_det [*5] |-> !led_data)
    else $error("data lamp on without valid data");
  AST_FOLLOW_SRC: assert property (!time_src_en |-> time_src_sel == 2'h0)
    else $error("time source selected while disabled");
  AST_TIME_REC: assert property (time_rec_en |-> time_src_en)
    else $error("time recorded by a follower");
  AST_FIRST_TICK: assert property (first_sample |-> sample_tick)
    else $error("first sample off a sample tick");
  AST_START_PULSE: assert property (tx_start |=> !tx_start)
    else $error("start request longer than one cycle");
  AST_STOP_LOCAL: assert property (tx_stop |-> !rec_active)
    else $error("stop sent while still recording");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held for two cycles");
  AST_ERR_READY: assert property (pslverr |-> pready && psel && penable)
    else $error("error response outside an access");
endmodule : msl_sync_ctrl_monitor
bind msl_sync_ctrl msl_sync_ctrl_monitor mon_u (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .rx_sig_det, .rx_valid_det, .led_sig_detect,
  .led_data, .tx_start, .tx_stop, .rec_active, .sample_tick, .first_sample,
  .time_src_sel, .time_src_en, .time_rec_en);
`default_nettype wire

// file: msl_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module msl_peer_model (
  input wire logic pclk,
  input wire logic [1:0] stage,
  input wire logic echo_en,
  input wire logic tx_start,
  input wire logic tx_pause,
  input wire logic tx_trig,
  input wire logic tx_stop,
  output logic rx_sig_det,
  output logic rx_align_det,
  output logic rx_valid_det,
  output logic rx_trig,
  output logic rx_start,
  output logic rx_pause,
  output logic rx_stop,
  output logic rx_tick
);
  logic [1:0] st_q = 2'h0, ps_q = 2'h0, tg_q = 2'h0, sp_q = 2'h0;
  logic [3:0] tk_q = 4'h0;
  // stage 3 is light without alignment, 1 aligned, 2 data
  assign rx_sig_det = stage != 2'h0;
  assign rx_align_det = stage == 2'h1 || stage == 2'h2;
  assign rx_valid_det = stage == 2'h2;
  // events idle low so every echo has its low phase
  assign rx_start = |st_q;
  assign rx_pause = |ps_q;
  assign rx_trig = |tg_q;
  assign rx_stop = |sp_q;
  assign rx_tick = rx_valid_det && tk_q == 4'h0;
  // one fiber, one far master echoing requests to its follower
  always @(posedge pclk) begin
    st_q <= {st_q[0], echo_en & rx_valid_det & tx_start};
    ps_q <= {ps_q[0], echo_en & rx_valid_det & tx_pause};
    tg_q <= {tg_q[0], echo_en & rx_valid_det & tx_trig};
    sp_q <= {sp_q[0], echo_en & rx_valid_det & tx_stop};
    tk_q <= (tk_q == 4'h9) ? 4'h0 : tk_q + 4'h1;
  end
endmodule : msl_peer_model
`default_nettype wire

// file: msl_sync_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module msl_sync_ctrl_tb_top;
  import msl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic chan_trig_in = 0, echo_en = 0, err;
  logic [1:0] stage = 2'h0, time_src_sel;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rx_sig_det, rx_align_det, rx_valid_det, rx_trig;
  logic rx_start, rx_pause, rx_stop, rx_tick, led_sig_detect, led_data;
  logic tx_trig, tx_start, tx_pause, tx_stop, tx_tick, sample_tick;
  logic first_sample, rec_active, rec_paused, trig_out, time_src_en;
  logic time_rec_en, irq;
  int num_errors = 0, checked = 0, n_txs = 0, n_ttr = 0, n_trg = 0;
  int n_fs = 0, n_tk = 0, n_tps = 0, n_tsp = 0, n_tt = 0;
  logic [1:0] stg[6] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
  logic [1:0] lmp[6] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3, 2'h0};
  logic [2:0] lk[6] = '{3'h1, 3'h2, 3'h4, 3'h2, 3'h4, 3'h1};
  always #50 pclk = ~pclk;
  msl_sync_ctrl dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .rx_sig_det, .rx_align_det,
    .rx_valid_det, .rx_trig, .rx_start, .rx_pause, .rx_stop, .rx_tick,
    .chan_trig_in, .led_sig_detect, .led_data, .tx_trig, .tx_start,
    .tx_pause, .tx_stop, .tx_tick, .sample_tick, .first_sample, .rec_active,
    .rec_paused, .trig_out, .time_src_sel, .time_src_en, .time_rec_en, .irq);
  msl_peer_model peer_u (.pclk, .stage, .echo_en, .tx_start, .tx_pause,
    .tx_trig, .tx_stop, .rx_sig_det, .rx_align_det, .rx_valid_det, .rx_trig,
    .rx_start, .rx_pause, .rx_stop, .rx_tick);
  // pulses are counted so no check has to hit the exact cycle
  always @(posedge pclk) begin
    n_txs += (tx_start === 1'b1);
    n_ttr += (tx_trig === 1'b1);
    n_trg += (trig_out === 1'b1);
    n_fs += (first_sample === 1'b1);
    n_tk += (sample_tick === 1'b1);
    n_tps += (tx_pause === 1'b1);
    n_tsp += (tx_stop === 1'b1);
    n_tt += (tx_tick === 1'b1);
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50)
      chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  function automatic logic [2:0] exp_src(input int m, input int s);
    return {m != 2, (m == 2) ? 2'h0 : s[1:0]};
  endfunction : exp_src
  initial begin
    int m, s, k;
    m = $urandom(53);
    cyc(4);
    presetn <= 1'b1;
    chk("time_src_en", 1, time_src_en);
    chk("rec_active", 0, rec_active);
    rdc(MSL_OFF_CTRL, 32'h0, "ctrl");
    rdc(MSL_OFF_SAMPLE_DIV, 32'h9, "div");
    apb(1'b1, 8'h1C, 32'h5);
    chk("unmapped err", 1, err);
    rdc(8'h1C, 32'h0, "unmapped");
    stage <= 2'h2;
    for (m = 0; m < 4; m += 3) begin
      apb(1'b1, MSL_OFF_CTRL, m);
      cyc(8);
      chk("lamps alone", 0, {led_sig_detect, led_data});
    end
    apb(1'b1, MSL_OFF_CTRL, {30'h0, MSL_MODE_MASTER});
    foreach (stg[i]) begin
      stage <= stg[i];
      cyc(8);
      chk("lamps", lmp[i], {led_sig_detect, led_data});
      rdc(MSL_OFF_STATUS, {25'h0, MSL_MODE_MASTER, 2'h0, lk[i]}, "link");
    end
    chk("irq masked", 0, irq);
    apb(1'b1, MSL_OFF_INT_MASK, 32'h1);
    cyc(2);
    chk("irq up", 1, irq);
    apb(1'b1, MSL_OFF_INT_STAT, 32'h1F);
    rdc(MSL_OFF_INT_STAT, 32'h0, "int clear");
    chk("irq clear", 0, irq);
    stage <= 2'h2;
    apb(1'b1, MSL_OFF_CABLE_DLY, 32'h3);
    apb(1'b1, MSL_OFF_INT_MASK, 32'h4);
    cyc(8);
    k = n_txs;
    s = n_fs;
    apb(1'b1, MSL_OFF_CMD, 32'h1 << MSL_CMD_START);
    cyc(2);
    chk("rec during delay", 0, rec_active);
    cyc(20);
    chk("rec start", 1, rec_active);
    chk("tx_start", k + 1, n_txs);
    chk("first_sample", s + 1, n_fs);
    chk("time_rec_en", 1, time_rec_en);
    chk("irq start", 1, irq);
    k = n_tps;
    apb(1'b1, MSL_OFF_CMD, 32'h1 << MSL_CMD_PAUSE);
    cyc(8);
    chk("rec_paused", 1, rec_paused);
    chk("tx_pause", k + 1, n_tps);
    k = n_tsp;
    apb(1'b1, MSL_OFF_CMD, 32'h1 << MSL_CMD_STOP);
    cyc(2);
    chk("rec stop", 0, rec_active);
    chk("paused stop", 0, rec_paused);
    // link came up again after the last clear, so bit 0 is set too
    rdc(MSL_OFF_INT_STAT, 32'hD, "start stop");
    chk("tx_stop", k + 1, n_tsp);
    apb(1'b1, MSL_OFF_INT_STAT, 32'h1F);
    k = n_trg;
    s = n_ttr;
    apb(1'b1, MSL_OFF_CMD, 32'h1 << MSL_CMD_TRIG);
    cyc(10);
    chan_trig_in <= 1'b1;
    cyc(1);
    chan_trig_in <= 1'b0;
    cyc(10);
    chk("trig_out", k + 2, n_trg);
    chk("tx_trig", s + 2, n_ttr);
    apb(1'b1, MSL_OFF_SAMPLE_DIV, 32'h3);
    cyc(4);
    k = n_tk;
    s = n_tt;
    cyc(40);
    chk("ticks", k + 10, n_tk);
    chk("tx_tick", s + 10, n_tt);
    // all mode and source pairs first, then random pairs
    for (int i = 0; i < 24; i++) begin
      m = (i < 16) ? i / 4 : $urandom % 4;
      s = (i < 16) ? i % 4 : $urandom % 4;
      apb(1'b1, MSL_OFF_CTRL, (s << MSL_CTRL_SRC_LSB) | m);
      cyc(3);
      chk("time src", exp_src(m, s), {time_src_en, time_src_sel});
    end
    echo_en <= 1'b1;
    apb(1'b1, MSL_OFF_CTRL, {30'h0, MSL_MODE_FOLLOW});
    cyc(8);
    k = n_txs;
    apb(1'b1, MSL_OFF_CMD, 32'h1 << MSL_CMD_START);
    cyc(20);
    chk("follow tx_start", k + 1, n_txs);
    chk("follow rec", 1, rec_active);
    chk("follow time_rec_en", 0, time_rec_en);
    apb(1'b1, MSL_OFF_CMD, 32'h1 << MSL_CMD_STOP);
    cyc(2);
    chk("follow stop", 0, rec_active);
    complete_run();
  end
  // the sequence needs about five hundred cycles; the limit lies at twenty thousand
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
endmodule : msl_sync_ctrl_tb_top
`default_nettype wire
